// File: hdl/gtl_chip_port.sv
module gtl_chip_port
  import gtl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              clk_en,
  // Sequencer side
  gtl_chip_if.port               bus,
  // Chip register port
  output logic [gtl_pkg::SEL_W-1:0] chip_sel,
  output logic                   chip_ce_n,
  output logic                   chip_we_n,
  output logic                   chip_rd,
  input  wire logic [7:0]        chip_d_in,
  output logic [7:0]             chip_d_out,
  output logic                   chip_d_oe
);

  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_STROBE, P_DONE} gtl_pst_t;
  typedef struct packed {
    gtl_pst_t         st;
    logic [CNT_W-1:0] cnt;
    logic [SEL_W-1:0] sel;
    logic             wr;
    logic [7:0]       wdata;
    logic [7:0]       rdata;
  } gtl_port_t;

  gtl_port_t r;
  gtl_port_t next_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequence
  always_comb
  begin
    next_r = r;
    unique case (r.st)
      P_IDLE:
        if (bus.req)
        begin
          next_r.st    = P_SETUP;
          next_r.sel   = bus.sel;
          next_r.wr    = bus.wr;
          next_r.wdata = bus.wdata;
        end
      P_SETUP:
      begin
        next_r.st  = P_STROBE;
        next_r.cnt = '0;
      end
      P_STROBE:
        if (r.cnt == STROBE_LAST)
        begin
          next_r.st    = P_DONE;
          next_r.rdata = r.wr ? r.rdata : chip_d_in;
        end
        else
          next_r.cnt = r.cnt + CNT_W'(1);
      P_DONE:
        next_r.st = P_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  assign bus.done   = (r.st == P_DONE);
  assign bus.rdata  = r.rdata;
  assign chip_sel   = r.sel;
  assign chip_ce_n  = (r.st != P_STROBE);
  assign chip_we_n  = !((r.st == P_STROBE) && r.wr);
  assign chip_rd    = !r.wr && (r.st != P_IDLE);
  assign chip_d_out = r.wdata;
  assign chip_d_oe  = r.wr && (r.st != P_IDLE);

endmodule // gtl_chip_port

// File: hdl/gtl_host.sv
//////////////////////////////////////////////////////////////////////////////
// Function
// R1: To stop a listener, an unlisten command must be sent.
// R2: Without pass bit, device answers primary addresses, goes active at once.
// R3: Primary active state lasts until unlisten, untalk or other talk address.
// R4: A new primary command drops the primary addressed state.
// R5: With pass bit set, own address only gives primary addressed state.
// R6: Secondary after own primary raises pass event and holds handshake.
// R7: Host reads passed secondary; if valid releases with set bit one.
// R8: Foreign secondary: release with set bit zero; stays primary addressed.
// R9: Sixteen interrupt sources, one status bit each in two registers.
// R10: Enabled, unmasked event sets summary bit and pulls interrupt low.
// R11: Reading an interrupt status register clears it.
// R12: Event during a status read is kept and set afterwards.
// R13: Disable-all keeps status bits but holds interrupt output high.
// R14: Disable-all leaves holdoffs on unknown addresses or commands intact.
// R15: Request-service bit raises service request; poll drops it again.
// R16: Host clears request-service after service, before the next request.
// R17: Other seven poll bits hold a host code used as poll response.
// R18: Bytes travel on eight lines, line one least significant.
// R19: Under attention only addresses and commands; then only addressed parties.
// R20: Talker marks last byte with end; listener treats it as last.
// R21: Talker waits for ready; data valid only after a stable byte.
// R22: Listener holds not-accepted until byte is captured.
// R23: Data written out appears on the bus with true as low level.
// R24: Incoming bus lines are synchronised before use.
module gtl_host
  import gtl_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  // Wishbone slave
  input  wire logic                      wb_cyc,
  input  wire logic                      wb_stb,
  input  wire logic                      wb_we,
  input  wire logic [gtl_pkg::WB_AW-1:0] wb_adr,
  input  wire logic [3:0]                wb_sel,
  input  wire logic [gtl_pkg::WB_DW-1:0] wb_wdata,
  output logic [gtl_pkg::WB_DW-1:0]      wb_rdata,
  output logic                           wb_ack,
  // Chip register port
  output logic [gtl_pkg::SEL_W-1:0]      chip_sel,
  output logic                           chip_ce_n,
  output logic                           chip_we_n,
  output logic                           chip_rd,
  input  wire logic [7:0]                chip_d_in,
  output logic [7:0]                     chip_d_out,
  output logic                           chip_d_oe,
  input  wire logic                      chip_int_n
);

  import gtl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_RST, S_ADDR, S_MASK0, S_MASK1, S_DAI, S_INT0, S_IRQ1,
    S_CPT, S_RELEASE, S_DIN, S_POLL, S_FEOI, S_DOUT, S_AUX
  } gtl_seq_t;

  typedef struct packed {
    gtl_seq_t          st;
    logic              ack;
    logic [WB_DW-1:0]  rdata;
    logic [ADDR_W-1:0] own_addr;
    logic [ADDR_W-1:0] sec_addr;
    logic              sec_mode;
    logic              int_off;
    logic              cfg_done;
    logic [CODE_W-1:0] poll_code;
    logic              rsv;
    logic              poll_dirty;
    logic [7:0]        tx_byte;
    logic              tx_last;
    logic              tx_full;
    logic              tx_ready;
    logic [7:0]        rx_byte;
    logic              rx_end;
    logic              rx_valid;
    logic              end_seen;
    logic              pend_din;
    logic              pend_cpt;
    logic [7:0]        cpt_byte;
    logic [7:0]        ev0;
    logic [7:0]        ev1;
    logic [7:0]        aux_cmd;
    logic              aux_req;
    logic              req;
    logic              wr;
    logic [SEL_W-1:0]  sel;
    logic [7:0]        wdata;
  } gtl_host_t;

  localparam logic [7:0] MASK0 = (ONE_HOT << BIT_BYTE_RECEIVED)
                               | (ONE_HOT << BIT_BYTE_SENT)
                               | (ONE_HOT << BIT_END)
                               | (ONE_HOT << BIT_POLL_ACTIVE)
                               | (ONE_HOT << BIT_ADDRESS_CHANGE);
  localparam logic [7:0] MASK1 = (ONE_HOT << BIT_UNKNOWN_COMMAND)
                               | (ONE_HOT << BIT_ADDRESSED);

  gtl_host_t r;
  gtl_host_t next_r;

  gtl_chip_if cif ();

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic gtl_host_t launch(input gtl_host_t s,
                                       input gtl_seq_t st,
                                       input logic wr,
                                       input logic [7:0] ofs,
                                       input logic [7:0] d);
    gtl_host_t o;
    o       = s;
    o.st    = st;
    o.req   = 1'b1;
    o.wr    = wr;
    o.sel   = reg_sel(ofs);
    o.wdata = d;
    return o;
  endfunction

  function automatic logic own_secondary(input logic [7:0] c,
                                         input logic [ADDR_W-1:0] a);
    return (c[ADDR_W+1:ADDR_W] == SCG_TAG) && (c[ADDR_W-1:0] == a);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  logic       take;
  logic       cfg_wr;
  logic       poll_wr;
  logic       tx_wr;
  logic       aux_wr;
  logic       rx_take;
  logic [7:0] clr0;
  logic [7:0] clr1;
  logic [7:0] rd;

  always_comb
  begin
    next_r  = r;
    take    = wb_cyc && wb_stb && !r.ack;
    cfg_wr  = 1'b0;
    poll_wr = 1'b0;
    tx_wr   = 1'b0;
    aux_wr  = 1'b0;
    rx_take = 1'b0;
    clr0    = '0;
    clr1    = '0;
    rd      = cif.rdata;
    next_r.ack = take;

    // Software access
    if (take)
    begin
      next_r.rdata = '0;
      case (wb_adr)
        WB_CFG:
        begin
          next_r.rdata[ADDR_W-1:0]              = r.own_addr;
          next_r.rdata[CFG_SEC_LSB +: ADDR_W]   = r.sec_addr;
          next_r.rdata[CFG_MODE_BIT]            = r.sec_mode;
          next_r.rdata[CFG_IOFF_BIT]            = r.int_off;
          if (wb_we)
          begin
            cfg_wr = 1'b1;
            if (wb_sel[0])
              next_r.own_addr = wb_wdata[ADDR_W-1:0];
            if (wb_sel[1])
              next_r.sec_addr = wb_wdata[CFG_SEC_LSB +: ADDR_W];
            if (wb_sel[2])
            begin
              next_r.sec_mode = wb_wdata[CFG_MODE_BIT];
              next_r.int_off  = wb_wdata[CFG_IOFF_BIT];
            end
          end
        end
        WB_POLL:
        begin
          next_r.rdata[CODE_W-1:0]   = r.poll_code;
          next_r.rdata[POLL_REQ_BIT] = r.rsv;
          if (wb_we && wb_sel[0])
            poll_wr = 1'b1;
        end
        WB_TX:
        begin
          next_r.rdata[7:0]        = r.tx_byte;
          next_r.rdata[TX_LAST_BIT] = r.tx_last;
          if (wb_we && wb_sel[0] && !r.tx_full)
            tx_wr = 1'b1;
        end
        WB_RX:
        begin
          next_r.rdata[7:0]          = r.rx_byte;
          next_r.rdata[RX_END_BIT]   = r.rx_end;
          next_r.rdata[RX_VALID_BIT] = r.rx_valid;
          rx_take = !wb_we;
        end
        WB_STAT:
        begin
          next_r.rdata[ST_BUSY_BIT]       = (r.st != S_IDLE);
          next_r.rdata[ST_TXFULL_BIT]     = r.tx_full;
          next_r.rdata[ST_RXVAL_BIT]      = r.rx_valid;
          next_r.rdata[ST_RSV_BIT]        = r.rsv;
          next_r.rdata[ST_READY_BIT]      = r.tx_ready;
          next_r.rdata[ST_EV0_LSB +: 8]   = r.ev0;
          next_r.rdata[ST_EV1_LSB +: 8]   = r.ev1;
          if (wb_we && wb_sel[1])
            clr0 = wb_wdata[ST_EV0_LSB +: 8];
          if (wb_we && wb_sel[2])
            clr1 = wb_wdata[ST_EV1_LSB +: 8];
        end
        WB_AUX:
        begin
          next_r.rdata[7:0] = r.aux_cmd;
          if (wb_we && wb_sel[0] && !r.aux_req)
            aux_wr = 1'b1;
        end
        default:
          next_r.rdata = '0;
      endcase
    end

    // Sequencer
    next_r.ev0      = r.ev0 & ~clr0;
    next_r.ev1      = r.ev1 & ~clr1;
    next_r.rx_valid = r.rx_valid && !rx_take;
    unique case (r.st)
      S_IDLE:
        if (!r.cfg_done)
          next_r = launch(next_r, S_RST, 1'b1, OFS_AUX,
                          aux_byte(1'b0, AUX_SWRST));
        else if (r.aux_req)
          next_r = launch(next_r, S_AUX, 1'b1, OFS_AUX, r.aux_cmd); // R1
        else if (r.pend_cpt)
          next_r = launch(next_r, S_CPT, 1'b0, OFS_CPT, '0); // R7
        else if (r.pend_din && !r.rx_valid)
          next_r = launch(next_r, S_DIN, 1'b0, OFS_DATA, '0); // R22
        else if (r.poll_dirty)
          next_r = launch(next_r, S_POLL, 1'b1, OFS_POLL,
                          poll_byte(r.rsv, r.poll_code)); // R17
        else if (r.tx_full && r.tx_ready && r.tx_last)
          next_r = launch(next_r, S_FEOI, 1'b1, OFS_AUX,
                          aux_byte(1'b0, AUX_FEOI)); // R20
        else if (r.tx_full && r.tx_ready)
          next_r = launch(next_r, S_DOUT, 1'b1, OFS_DATA, r.tx_byte); // R21
        else if (r.int_off || !chip_int_n)
          next_r = launch(next_r, S_INT0, 1'b0, OFS_INT0, '0); // R13
      default:
        if (cif.done)
        begin
          next_r.req = 1'b0;
          next_r.st  = S_IDLE;
          unique case (r.st)
            S_RST:
              next_r = launch(next_r, S_ADDR, 1'b1, OFS_ADDR,
                              {3'h0, r.own_addr});
            S_ADDR:
              next_r = launch(next_r, S_MASK0, 1'b1, OFS_INT0, MASK0);
            S_MASK1:
              next_r = launch(next_r, S_DAI, 1'b1, OFS_AUX,
                              aux_byte(r.int_off, AUX_DAI)); // R13
            S_MASK0:
              next_r = launch(next_r, S_MASK1, 1'b1, OFS_IRQ1,
                              MASK1 | ({7'h0, r.sec_mode}
                                       << BIT_SECONDARY_PASS)); // R5
            S_DAI:
              next_r.cfg_done = 1'b1;
            S_INT0:
            begin
              next_r.ev0 = next_r.ev0 | rd; // R11
              if (rd[BIT_BYTE_RECEIVED])
                next_r.pend_din = 1'b1;
              if (rd[BIT_END])
                next_r.end_seen = 1'b1; // R20
              if (rd[BIT_BYTE_SENT])
                next_r.tx_ready = 1'b1; // R21
              if (rd[BIT_POLL_ACTIVE] && r.rsv)
              begin
                next_r.rsv        = 1'b0; // R16
                next_r.poll_dirty = 1'b1; // R15
              end
              next_r = launch(next_r, S_IRQ1, 1'b0, OFS_IRQ1, '0);
            end
            S_IRQ1:
            begin
              next_r.ev1 = next_r.ev1 | rd; // R11
              if (rd[BIT_SECONDARY_PASS])
                next_r.pend_cpt = 1'b1; // R6
            end
            S_CPT:
            begin
              next_r.cpt_byte = rd;
              next_r.pend_cpt = 1'b0;
              next_r = launch(next_r, S_RELEASE, 1'b1, OFS_AUX,
                              aux_byte(own_secondary(rd, r.sec_addr),
                                       AUX_DACR)); // R7 R8
            end
            S_DIN:
            begin
              next_r.rx_byte  = rd; // R18
              next_r.rx_valid = 1'b1;
              next_r.rx_end   = r.end_seen; // R20
              next_r.end_seen = 1'b0;
              next_r.pend_din = 1'b0;
            end
            S_POLL:
              next_r.poll_dirty = 1'b0;
            S_FEOI:
              next_r = launch(next_r, S_DOUT, 1'b1, OFS_DATA,
                              r.tx_byte); // R18
            S_DOUT:
            begin
              next_r.tx_full  = 1'b0;
              next_r.tx_ready = 1'b0; // R21
            end
            S_AUX:
              next_r.aux_req = 1'b0;
            S_RELEASE:
              next_r.st = S_IDLE;
            default:
              next_r.st = S_IDLE;
          endcase
        end
    endcase

    // Software requests, after the sequencer so they are not lost
    if (cfg_wr)
      next_r.cfg_done = 1'b0;
    if (poll_wr)
    begin
      next_r.poll_code  = wb_wdata[CODE_W-1:0]; // R17
      if (!(r.rsv && wb_wdata[POLL_REQ_BIT]))
        next_r.rsv = wb_wdata[POLL_REQ_BIT]; // R16
      next_r.poll_dirty = 1'b1; // R15
    end
    if (tx_wr)
    begin
      next_r.tx_byte = wb_wdata[7:0]; // R18
      next_r.tx_last = wb_wdata[TX_LAST_BIT];
      next_r.tx_full = 1'b1;
    end
    if (aux_wr)
    begin
      next_r.aux_cmd = wb_wdata[7:0];
      next_r.aux_req = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      r <= '0;
    else if (clk_en)
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip port
  assign cif.req   = r.req;
  assign cif.wr    = r.wr;
  assign cif.sel   = r.sel;
  assign cif.wdata = r.wdata;

  gtl_chip_port u_port (
    .clk        (clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .bus        (cif.port),
    .chip_sel   (chip_sel),
    .chip_ce_n  (chip_ce_n),
    .chip_we_n  (chip_we_n),
    .chip_rd    (chip_rd),
    .chip_d_in  (chip_d_in),
    .chip_d_out (chip_d_out),
    .chip_d_oe  (chip_d_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus outputs
  assign wb_rdata = r.rdata;
  assign wb_ack   = r.ack;

endmodule // gtl_host

// File: include/gtl_chip_if.sv
interface gtl_chip_if;
  logic                     req;
  logic                     wr;
  logic [gtl_pkg::SEL_W-1:0] sel;
  logic [7:0]               wdata;
  logic                     done;
  logic [7:0]               rdata;

  modport ctrl (output req, wr, sel, wdata, input done, rdata);
  modport port (input req, wr, sel, wdata, output done, rdata);
endinterface

// File: include/gtl_pkg.sv
package gtl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and chip access timing
  localparam int CLK_NS      = 10;
  localparam int T_STROBE_NS = 150;
  localparam int STROBE_CYC  = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 5;
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Chip register offsets
  localparam logic [7:0] OFS_INT0 = 8'hC0;
  localparam logic [7:0] OFS_IRQ1 = 8'hC2;
  localparam logic [7:0] OFS_ADST = 8'hC4;
  localparam logic [7:0] OFS_AUX  = 8'hC6;
  localparam logic [7:0] OFS_ADDR = 8'hC8;
  localparam logic [7:0] OFS_POLL = 8'hCA;
  localparam logic [7:0] OFS_CPT  = 8'hCC;
  localparam logic [7:0] OFS_DATA = 8'hCE;
  localparam int SEL_W = 3;

  // Interrupt register bits
  localparam int BIT_BYTE_RECEIVED   = 5;
  localparam int BIT_BYTE_SENT       = 4;
  localparam int BIT_END             = 3;
  localparam int BIT_POLL_ACTIVE     = 2;
  localparam int BIT_ADDRESS_CHANGE  = 0;
  localparam int BIT_UNKNOWN_COMMAND = 5;
  localparam int BIT_SECONDARY_PASS  = 4;
  localparam int BIT_ADDRESSED       = 2;
  localparam logic [7:0] ONE_HOT    = 8'h01;

  // Auxiliary commands
  localparam int AUX_CS_BIT = 7;
  localparam logic [4:0] AUX_SWRST = 5'h00;
  localparam logic [4:0] AUX_DACR  = 5'h01;
  localparam logic [4:0] AUX_FEOI  = 5'h08;
  localparam logic [4:0] AUX_DAI   = 5'h13;

  // Poll byte and secondary group
  localparam int CODE_W  = 7;
  localparam int ADDR_W  = 5;
  localparam logic [1:0] SCG_TAG = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Own Wishbone registers
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;
  localparam logic [WB_AW-1:0] WB_CFG  = 8'h00;
  localparam logic [WB_AW-1:0] WB_POLL = 8'h04;
  localparam logic [WB_AW-1:0] WB_TX   = 8'h08;
  localparam logic [WB_AW-1:0] WB_RX   = 8'h0C;
  localparam logic [WB_AW-1:0] WB_STAT = 8'h10;
  localparam logic [WB_AW-1:0] WB_AUX  = 8'h14;
  localparam int CFG_SEC_LSB   = 8;
  localparam int CFG_MODE_BIT  = 16;
  localparam int CFG_IOFF_BIT  = 17;
  localparam int POLL_REQ_BIT  = 7;
  localparam int TX_LAST_BIT   = 8;
  localparam int RX_END_BIT    = 8;
  localparam int RX_VALID_BIT  = 9;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_TXFULL_BIT = 1;
  localparam int ST_RXVAL_BIT  = 2;
  localparam int ST_RSV_BIT    = 3;
  localparam int ST_READY_BIT  = 4;
  localparam int ST_EV0_LSB    = 8;
  localparam int ST_EV1_LSB    = 16;

  function automatic logic [SEL_W-1:0] reg_sel(input logic [7:0] ofs);
    logic [7:0] d;
    d = ofs - OFS_INT0;
    return d[SEL_W:1];
  endfunction

  function automatic logic [7:0] aux_byte(input logic cs,
                                          input logic [4:0] code);
    logic [7:0] b;
    b = {3'h0, code};
    b[AUX_CS_BIT] = cs;
    return b;
  endfunction

  function automatic logic [7:0] poll_byte(input logic rsv,
                                           input logic [CODE_W-1:0] c);
    return {c[CODE_W-1], rsv, c[CODE_W-2:0]};
  endfunction

endpackage

// File: verif/gtl_chip_model.sv
module gtl_chip_model
  import gtl_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // Register port
  input  wire logic [gtl_pkg::SEL_W-1:0] chip_sel,
  input  wire logic                      chip_ce_n,
  input  wire logic                      chip_we_n,
  input  wire logic                      chip_rd,
  input  wire logic [7:0]                chip_d_out,
  output logic [7:0]                     chip_d_in,
  output logic                           chip_int_n,
  // Bench side
  input  wire logic [7:0]                ev0,
  input  wire logic [7:0]                rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] st0, msk0, msk1, poll, dout, last, rv;
  logic       off, ce_q, go, rd_end;

  assign go         = !chip_ce_n && ce_q;
  assign rd_end     = chip_ce_n && !ce_q && chip_rd;
  assign chip_int_n = off || (st0 & msk0) == 8'h00;
  // Released data lines toggle every cycle
  assign chip_d_in  = (chip_rd && !chip_ce_n) ? rv : ~last;

  always_comb
    case (chip_sel)
      3'h0:    rv = {|(st0[6:0] & msk0[6:0]), st0[6:0]};
      3'h7:    rv = rx_byte;
      default: rv = 8'h00;
    endcase

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {st0, msk0, msk1, poll, dout, last} <= '0;
      off  <= 1'b0;
      ce_q <= 1'b1;
    end
    else
    begin
      ce_q <= chip_ce_n;
      last <= chip_d_in;
      st0  <= ((rd_end && chip_sel == 3'h0) ? st0 & ~last : st0)
              | ev0;
      if (go && !chip_we_n)
        case (chip_sel)
          3'h0:    msk0 <= chip_d_out;
          3'h1:    msk1 <= chip_d_out;
          3'h3:    if (chip_d_out[4:0] == AUX_DAI)
                     off <= chip_d_out[7];
          3'h5:    poll <= chip_d_out;
          3'h7:    dout <= chip_d_out;
          default: ;
        endcase
    end
endmodule  // gtl_chip_model

// File: verif/gtl_host_chk.sv
module gtl_host_chk
  import gtl_pkg::*;
(
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic                      clk_en,
  // Wishbone
  input wire logic                      wb_cyc,
  input wire logic                      wb_stb,
  input wire logic                      wb_ack,
  // Chip port
  input wire logic [gtl_pkg::SEL_W-1:0] chip_sel,
  input wire logic                      chip_ce_n,
  input wire logic                      chip_we_n,
  input wire logic                      chip_rd,
  input wire logic [7:0]                chip_d_out,
  input wire logic                      chip_d_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_low8;
    !chip_ce_n [*8];
  endsequence
  sequence s_low7;
    !chip_ce_n [*7];
  endsequence

  chk_ack_pulse: assert property (wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (
    wb_cyc && wb_stb && !wb_ack && clk_en |=> wb_ack)
    else $error("request not answered next cycle");
  chk_strobe_len: assert property (
    $fell(chip_ce_n) |-> s_low8 ##1 s_low7 ##1 chip_ce_n)
    else $error("strobe not fifteen cycles");
  chk_write_strobe: assert property (
    !chip_we_n |-> !chip_ce_n && chip_d_oe && !chip_rd)
    else $error("write strobe outside driven access");
  chk_addr_hold: assert property (
    !chip_ce_n |-> $stable(chip_sel) && $stable(chip_d_out))
    else $error("select or data moved in strobe");
  chk_read_float: assert property (chip_rd |-> !chip_d_oe && chip_we_n)
    else $error("data driven during read");
  chk_oe_release: assert property (
    $rose(chip_ce_n) && chip_d_oe |=> !chip_d_oe && chip_ce_n)
    else $error("data still driven after done");
  chk_setup_cycle: assert property (
    $fell(chip_ce_n) |-> $past(chip_d_oe || chip_rd))
    else $error("strobe without setup cycle");
  chk_access_gap: assert property ($rose(chip_ce_n) |-> chip_ce_n [*3])
    else $error("accesses too close");
endmodule  // gtl_host_chk

bind gtl_host gtl_host_chk gtl_host_chk_inst (
  .clk(clk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .wb_cyc(wb_cyc),
  .wb_stb(wb_stb),
  .wb_ack(wb_ack),
  .chip_sel(chip_sel),
  .chip_ce_n(chip_ce_n),
  .chip_we_n(chip_we_n),
  .chip_rd(chip_rd),
  .chip_d_out(chip_d_out),
  .chip_d_oe(chip_d_oe)
);

// File: verif/testbench.sv
module testbench
  import gtl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [WB_AW-1:0] wb_adr;
  logic [WB_DW-1:0] wb_wdata, wb_rdata;
  logic [3:0]       wb_sel;
  logic [SEL_W-1:0] chip_sel;
  logic             chip_ce_n, chip_we_n, chip_rd, chip_d_oe, chip_int_n;
  logic [7:0]       chip_d_in, chip_d_out, ev0, rx_byte;
  int               num_errors = 0;
  int               tests_run = 0;

  gtl_host gtl_host_inst (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(1'b1),
    .wb_cyc(wb_cyc),
    .wb_stb(wb_stb),
    .wb_we(wb_we),
    .wb_adr(wb_adr),
    .wb_sel(wb_sel),
    .wb_wdata(wb_wdata),
    .wb_rdata(wb_rdata),
    .wb_ack(wb_ack),
    .chip_sel(chip_sel),
    .chip_ce_n(chip_ce_n),
    .chip_we_n(chip_we_n),
    .chip_rd(chip_rd),
    .chip_d_in(chip_d_in),
    .chip_d_out(chip_d_out),
    .chip_d_oe(chip_d_oe),
    .chip_int_n(chip_int_n)
  );

  gtl_chip_model gtl_chip_model_inst (
    .clk(clk),
    .arst_n(arst_n),
    .chip_sel(chip_sel),
    .chip_ce_n(chip_ce_n),
    .chip_we_n(chip_we_n),
    .chip_rd(chip_rd),
    .chip_d_out(chip_d_out),
    .chip_d_in(chip_d_in),
    .chip_int_n(chip_int_n),
    .ev0(ev0),
    .rx_byte(rx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic wb_io(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_wdata <= d;
    wb_sel   <= 4'hF;
    do @(posedge clk); while (wb_ack !== 1'b1);
    q = wb_rdata;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle();
    logic [31:0] q;
    int          n;
    int          k;
    n = 0;
    k = 0;
    repeat (4) @(posedge clk);
    while (k < 2 && n++ < 100)
    begin
      wb_io(1'b0, WB_STAT, 32'h0, q);
      k = (q[ST_BUSY_BIT] === 1'b0) ? k + 1 : 0;
    end
    num_errors += int'(k < 2);
  endtask

  task automatic fire(input logic [7:0] e);
    @(posedge clk);
    ev0 <= e;
    @(posedge clk);
    ev0 <= 8'h00;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_init();
    idle();
    chk(32'(gtl_chip_model_inst.msk0), 32'h3D);
    chk(32'(gtl_chip_model_inst.msk1), 32'h24);
    chk(32'(gtl_chip_model_inst.off), 32'h0);
    $display("init test done");
  endtask

  task automatic t_poll();
    logic [31:0] q;
    wb_io(1'b1, WB_POLL, 32'hAA, q);
    idle();
    chk(32'(gtl_chip_model_inst.poll), 32'h6A);
    fire(8'h04);
    idle();
    chk(32'(gtl_chip_model_inst.poll), 32'h2A);
    chk(32'(gtl_chip_model_inst.st0), 32'h0);
    wb_io(1'b0, WB_POLL, 32'h0, q);
    chk(q, 32'h2A);
    $display("poll test done");
  endtask

  task automatic t_rx();
    logic [31:0] q;
    rx_byte <= 8'hA5;
    fire(8'h20);
    idle();
    wb_io(1'b0, WB_RX, 32'h0, q);
    chk(q, 32'h2A5);
    wb_io(1'b0, WB_RX, 32'h0, q);
    chk(q & 32'h200, 32'h0);
    $display("receive test done");
  endtask

  task automatic t_tx();
    logic [31:0] q;
    fire(8'h10);
    idle();
    wb_io(1'b1, WB_TX, 32'h5A, q);
    idle();
    chk(32'(gtl_chip_model_inst.dout), 32'h5A);
    wb_io(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h0);
    $display("send test done");
  endtask

  task automatic t_dai();
    logic [31:0] q;
    int          n;
    n = 0;
    wb_io(1'b1, WB_CFG, 32'h0002_0005, q);
    while (gtl_chip_model_inst.off !== 1'b1 && n++ < 500) @(posedge clk);
    chk(32'(gtl_chip_model_inst.off), 32'h1);
    fire(8'h01);
    @(negedge clk);
    chk(32'(chip_int_n), 32'h1);
    repeat (100) @(posedge clk);
    wb_io(1'b0, WB_STAT, 32'h0, q);
    chk(32'(q[ST_EV0_LSB]), 32'h1);
    $display("disable test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, sequence, watchdog
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    arst_n   = 1'b0;
    wb_cyc   = 1'b0;
    wb_stb   = 1'b0;
    wb_we    = 1'b0;
    wb_adr   = 8'h00;
    wb_wdata = 32'h0;
    wb_sel   = 4'h0;
    ev0      = 8'h00;
    rx_byte  = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_init();
    t_poll();
    t_rx();
    t_tx();
    t_dai();
    close_out();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule  // testbench
